// ===== design/power_mode_ctrl.v
// Low-power mode sequencer with reset and interrupt vector selection.
`timescale 1ns/1ps
`include "power_vec_regs.vh"
module power_mode_ctrl #(
  parameter NUM_SRC = 16,
  parameter GATE_W  = 8
) (
  input  wire                core_clk,
  input  wire                rst_n,
  input  wire                clk_en,
  input  wire [7:0]          reg_addr,
  input  wire [15:0]         reg_wdata,
  input  wire                reg_wr,
  input  wire                reg_rd,
  output reg  [15:0]         reg_rdata_q,
  input  wire                stop_exec,
  input  wire                wait_exec,
  input  wire                nvm_busy,
  input  wire                cpu_x_mask,
  input  wire                cpu_i_mask,
  input  wire                nonmaskable_request_pin_n,
  input  wire                maskable_request_pin_n,
  input  wire [NUM_SRC-1:0]  int_req,
  input  wire                periodic_wake_req,
  input  wire                analog_wake_req,
  input  wire                background_debug_active,
  input  wire                low_voltage_evt,
  input  wire                illegal_addr_evt,
  input  wire                clock_monitor_fail,
  input  wire                watchdog_timeout,
  output reg  [2:0]          mode_q,
  output reg                 sys_clk_run_q,
  output reg                 cpu_clk_run_q,
  output reg                 osc_run_q,
  output reg                 pll_self_clk_q,
  output reg                 tick_run_q,
  output reg                 watchdog_run_q,
  output reg                 display_run_q,
  output reg                 periodic_run_q,
  output reg                 analog_run_q,
  output reg                 periph_on_q,
  output reg  [GATE_W-1:0]   periph_clk_gate_q,
  output reg                 freeze_timer_q,
  output reg                 freeze_pwm_q,
  output reg                 freeze_analog_q,
  output reg                 int_valid_q,
  output reg  [15:0]         int_vector_q,
  output reg                 sys_reset_req_q,
  output reg  [15:0]         reset_vector_q
);

  // Mode encodings; mode_q shows the same codes to the rest of the chip.
  localparam [2:0] ST_RUN   = 3'h0;
  localparam [2:0] ST_DEFER = 3'h1;
  localparam [2:0] ST_PSTOP = 3'h2;
  localparam [2:0] ST_FSTOP = 3'h3;
  localparam [2:0] ST_WAIT  = 3'h4;

  // Software-visible control registers and the mode state.
  reg  [6:0]          clock_select_q;
  reg  [7:0]          vector_base_q;
  reg  [NUM_SRC-1:0]  int_enable_q;
  reg  [2:0]          freeze_ctrl_q;
  reg  [GATE_W-1:0]   clock_gate_q;
  reg  [4:0]          reset_ctrl_q;
  reg  [1:0]          nmi_sync_q;
  reg  [1:0]          irq_sync_q;
  reg  [2:0]          state_q;
  reg  [2:0]          state_d;
  reg  [1:0]          last_reset_q;

  // Interrupt arbitration and reset source nets.
  wire [NUM_SRC-1:0]  req_all;
  wire [NUM_SRC-1:0]  pend;
  wire                wd_enabled;
  wire                stop_wake;
  wire                any_pend;
  wire                reset_evt;

  reg  [4:0]          win_idx;
  reg                 win_found;
  reg  [15:0]         win_vector;
  reg  [15:0]         rd_mux;
  integer             k;

  // The first stage of each pin synchroniser feeds only the second stage.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      nmi_sync_q <= 2'h3;
      irq_sync_q <= 2'h3;
    end else if (clk_en) begin
      nmi_sync_q <= {nmi_sync_q[0], nonmaskable_request_pin_n};
      irq_sync_q <= {irq_sync_q[0], maskable_request_pin_n};
    end
  end

  // Request pins are active low and replace their slots in the source vector.
  assign req_all = {int_req[NUM_SRC-1:4], ~irq_sync_q[1], ~nmi_sync_q[1], int_req[1:0]};

  // Each source is pending when raised, locally enabled and not masked by the processor.
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g = g + 1) begin : gen_pend
      if (g < `SRC_NONMASKABLE) begin : g_nomask
        assign pend[g] = req_all[g] & int_enable_q[g];
      end else if (g == `SRC_NONMASKABLE) begin : g_xmask
        assign pend[g] = req_all[g] & int_enable_q[g] & ~cpu_x_mask;
      end else begin : g_imask
        assign pend[g] = req_all[g] & int_enable_q[g] & ~cpu_i_mask;
      end
    end
  endgenerate

  // Wait and a deferred stop end on any pending source, timer channels included.
  assign any_pend = |pend;

  // Only a reset event, the pins and the self-waking units may end a stop; timer sources cannot.
  assign stop_wake = pend[`SRC_NONMASKABLE] | pend[`SRC_MASKABLE]
                   | (periodic_wake_req & clock_select_q[`CS_PERIODIC_EN])
                   | (analog_wake_req & clock_select_q[`CS_ANALOG_EN]);

  // Lowest index wins; offsets descend by two from the first entry.
  always @* begin
    win_idx   = 5'h00;
    win_found = 1'b0;
    for (k = NUM_SRC - 1; k >= 0; k = k - 1) begin
      if (pend[k]) begin
        win_idx   = k[4:0];
        win_found = 1'b1;
      end
    end
    win_vector = {vector_base_q, `VEC_FIRST_OFFSET - {2'h0, win_idx, 1'b0}};
  end

  // The clock monitor resets only when self-clock mode is not taken instead.
  assign wd_enabled = |reset_ctrl_q[`RC_WD_RATE_MSB:`RC_WD_RATE_LSB];
  assign reset_evt  = low_voltage_evt | illegal_addr_evt
                    | (clock_monitor_fail & reset_ctrl_q[`RC_CLOCK_MON_EN] & ~reset_ctrl_q[`RC_SELF_CLOCK_EN])
                    | (watchdog_timeout & wd_enabled);

  // Mode sequencer; a reset event overrides every transition and returns to run.
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (stop_exec) begin
          if (nvm_busy) begin
            state_d = ST_DEFER;
          end else if (clock_select_q[`CS_PSEUDO_STOP]) begin
            state_d = ST_PSTOP;
          end else begin
            state_d = ST_FSTOP;
          end
        end else if (wait_exec) begin
          state_d = ST_WAIT;
        end
      end
      ST_DEFER: begin
        // The memory command keeps the clocks running; a pending source cancels the stop.
        if (any_pend) begin
          state_d = ST_RUN;
        end else if (!nvm_busy) begin
          state_d = clock_select_q[`CS_PSEUDO_STOP] ? ST_PSTOP : ST_FSTOP;
        end
      end
      ST_PSTOP: begin
        if (stop_wake) begin
          state_d = ST_RUN;
        end
      end
      ST_FSTOP: begin
        if (stop_wake) begin
          state_d = ST_RUN;
        end
      end
      ST_WAIT: begin
        if (any_pend) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
    if (reset_evt) begin
      state_d = ST_RUN;
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_RUN;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  // Register writes.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clock_select_q <= `CLOCK_SELECT_RST;
      vector_base_q  <= `VECTOR_BASE_RST;
      int_enable_q   <= `INT_ENABLE_RST;
      freeze_ctrl_q  <= 3'h0;
      clock_gate_q   <= {GATE_W{1'b0}};
      reset_ctrl_q   <= `RESET_CTRL_RST;
    end else if (clk_en && reg_wr) begin
      case (reg_addr)
        `ADDR_CLOCK_SELECT: clock_select_q <= reg_wdata[6:0];
        `ADDR_VECTOR_BASE:  vector_base_q  <= reg_wdata[7:0];
        `ADDR_INT_ENABLE:   int_enable_q   <= reg_wdata[NUM_SRC-1:0] | `INT_ENABLE_RST;
        `ADDR_FREEZE_CTRL:  freeze_ctrl_q  <= reg_wdata[2:0];
        `ADDR_CLOCK_GATE:   clock_gate_q   <= reg_wdata[GATE_W-1:0];
        `ADDR_RESET_CTRL:   reset_ctrl_q   <= reg_wdata[4:0];
        default: begin
        end
      endcase
    end
  end

  // Read multiplexer; unmapped offsets read as zero.
  always @* begin
    case (reg_addr)
      `ADDR_CLOCK_SELECT: rd_mux = {9'h000, clock_select_q};
      `ADDR_VECTOR_BASE:  rd_mux = {8'h00, vector_base_q};
      `ADDR_INT_ENABLE:   rd_mux = int_enable_q;
      `ADDR_FREEZE_CTRL:  rd_mux = {13'h0000, freeze_ctrl_q};
      `ADDR_CLOCK_GATE:   rd_mux = {8'h00, clock_gate_q};
      `ADDR_RESET_CTRL:   rd_mux = {11'h000, reset_ctrl_q};
      `ADDR_STATUS:       rd_mux = {8'h00, last_reset_q, win_found, any_pend, pll_self_clk_q, state_q};
      `ADDR_VECTOR:       rd_mux = win_vector;
      default:            rd_mux = 16'h0000;
    endcase
  end

  // Read data stand for one cycle after the strobe and are zero otherwise.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= 16'h0000;
    end else if (clk_en) begin
      reg_rdata_q <= reg_rd ? rd_mux : 16'h0000;
    end
  end

  // Clock and peripheral controls follow the next state so they switch with the mode.
  // After a fast wake the loop self clock stays in charge until software clears the option or a stop is entered.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q            <= ST_RUN;
      sys_clk_run_q     <= 1'b1;
      cpu_clk_run_q     <= 1'b1;
      osc_run_q         <= 1'b1;
      pll_self_clk_q    <= 1'b0;
      tick_run_q        <= 1'b1;
      watchdog_run_q    <= 1'b1;
      display_run_q     <= 1'b1;
      periodic_run_q    <= 1'b0;
      analog_run_q      <= 1'b0;
      periph_on_q       <= 1'b1;
      periph_clk_gate_q <= {GATE_W{1'b0}};
    end else if (clk_en) begin
      mode_q            <= state_d;
      sys_clk_run_q     <= (state_d == ST_RUN) || (state_d == ST_DEFER) || (state_d == ST_WAIT);
      cpu_clk_run_q     <= (state_d == ST_RUN) || (state_d == ST_DEFER);
      periph_on_q       <= (state_d == ST_RUN) || (state_d == ST_DEFER) || (state_d == ST_WAIT);
      periph_clk_gate_q <= (state_d == ST_WAIT) ? clock_gate_q : {GATE_W{1'b0}};
      periodic_run_q    <= clock_select_q[`CS_PERIODIC_EN];
      analog_run_q      <= clock_select_q[`CS_ANALOG_EN];
      if (state_d == ST_PSTOP) begin
        tick_run_q     <= clock_select_q[`CS_TICK_EN];
        watchdog_run_q <= clock_select_q[`CS_WATCHDOG_EN];
        display_run_q  <= clock_select_q[`CS_DISPLAY_EN];
      end else begin
        tick_run_q     <= (state_d != ST_FSTOP);
        watchdog_run_q <= (state_d != ST_FSTOP);
        display_run_q  <= (state_d != ST_FSTOP);
      end
      if (state_d == ST_FSTOP) begin
        osc_run_q      <= 1'b0;
        pll_self_clk_q <= 1'b0;
      end else if (state_d == ST_PSTOP) begin
        // Pseudo stop keeps the oscillator alive, which also ends a self-clocked spell.
        osc_run_q      <= 1'b1;
        pll_self_clk_q <= 1'b0;
      end else if (state_q == ST_FSTOP && clock_select_q[`CS_FAST_WAKE]) begin
        osc_run_q      <= 1'b0;
        pll_self_clk_q <= 1'b1;
      end else if (pll_self_clk_q && !clock_select_q[`CS_FAST_WAKE]) begin
        osc_run_q      <= 1'b1;
        pll_self_clk_q <= 1'b0;
      end else if (!pll_self_clk_q) begin
        osc_run_q      <= 1'b1;
      end
    end
  end

  // Freeze outputs follow the debug state only where software has asked for it.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      freeze_timer_q  <= 1'b0;
      freeze_pwm_q    <= 1'b0;
      freeze_analog_q <= 1'b0;
    end else if (clk_en) begin
      freeze_timer_q  <= background_debug_active & freeze_ctrl_q[0];
      freeze_pwm_q    <= background_debug_active & freeze_ctrl_q[1];
      freeze_analog_q <= background_debug_active & freeze_ctrl_q[2];
    end
  end

  // The winner is registered every cycle; valid rises only when the next mode is run.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_valid_q  <= 1'b0;
      int_vector_q <= 16'h0000;
    end else if (clk_en) begin
      int_valid_q  <= win_found && (state_d == ST_RUN);
      int_vector_q <= win_found ? win_vector : 16'h0000;
    end
  end

  // Reset vector: clock monitor and watchdog win their own vectors, all else shares one.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_reset_req_q <= 1'b0;
      reset_vector_q  <= `VEC_RESET;
      last_reset_q    <= 2'h0;
    end else if (clk_en) begin
      sys_reset_req_q <= reset_evt;
      if (low_voltage_evt || illegal_addr_evt) begin
        reset_vector_q <= `VEC_RESET;
        last_reset_q   <= 2'h1;
      end else if (clock_monitor_fail && reset_ctrl_q[`RC_CLOCK_MON_EN] && !reset_ctrl_q[`RC_SELF_CLOCK_EN]) begin
        reset_vector_q <= `VEC_CLOCK_MON;
        last_reset_q   <= 2'h2;
      end else if (watchdog_timeout && wd_enabled) begin
        reset_vector_q <= `VEC_WATCHDOG;
        last_reset_q   <= 2'h3;
      end
    end
  end

endmodule

// ===== design/power_vec_regs.vh
// Register offsets, field positions, reset values and vector constants of the power and vector controller.
// Behaviour
// - A stop instruction enters system stop unless a memory command is active.
// - Stop entry picks pseudo stop when pseudo_stop_select is set, else full stop.
// - Reset, either request pin, periodic wakeup or analog converter leaves stop.
// - Stop during a memory command keeps system clocks running until it finishes.
// - An unmasked interrupt during deferred stop entry abandons the stop.
// - Full stop halts the oscillator and gates every clock off.
// - Periodic wakeup and analog converter may run in full stop and wake it.
// - Fast wakeup resumes from full stop on the loop self clock, oscillator off.
// - Pseudo stop stops system clocks, keeps oscillator; few units may stay on.
// - Wait instruction enters wait, gates processor clock and stops execution.
// - In wait peripherals run and each may gate its own clock.
// - Reset, either request pin or any unmasked interrupt ends wait.
// - Timer, modulator and converter may each freeze while debug is active.
// - Power-on, low voltage, pin and illegal address resets share one vector.
// - Clock monitor and watchdog resets have their own vectors and enables.
// - Interrupt vector is the base register plus a fixed per-source offset.
// - Priority: trap, software interrupt, nonmaskable pin, maskable pin, tick.
// - First timer channels, overflow and accumulator follow; they wake wait only.
`ifndef POWER_VEC_REGS_VH
`define POWER_VEC_REGS_VH
`define ADDR_CLOCK_SELECT  8'h00
`define ADDR_VECTOR_BASE   8'h01
`define ADDR_INT_ENABLE    8'h02
`define ADDR_FREEZE_CTRL   8'h03
`define ADDR_CLOCK_GATE    8'h04
`define ADDR_RESET_CTRL    8'h05
`define ADDR_STATUS        8'h06
`define ADDR_VECTOR        8'h07
`define CS_PSEUDO_STOP     0
`define CS_FAST_WAKE       1
`define CS_PERIODIC_EN     2
`define CS_ANALOG_EN       3
`define CS_TICK_EN         4
`define CS_WATCHDOG_EN     5
`define CS_DISPLAY_EN      6
`define RC_CLOCK_MON_EN    0
`define RC_SELF_CLOCK_EN   1
`define RC_WD_RATE_LSB     2
`define RC_WD_RATE_MSB     4
`define CLOCK_SELECT_RST   7'h00
`define VECTOR_BASE_RST    8'hFF
`define INT_ENABLE_RST     16'h0003
`define RESET_CTRL_RST     5'h01
`define VEC_RESET          16'hFFFE
`define VEC_CLOCK_MON      16'hFFFC
`define VEC_WATCHDOG       16'hFFFA
`define VEC_FIRST_OFFSET   8'hF8
`define SRC_NONMASKABLE    2
`define SRC_MASKABLE       3
`endif

// ===== tb/cpu_core_model.sv
// Processor core model that executes stop and wait instructions on request.
`timescale 1ns/1ps
module cpu_core_model (
  input  wire core_clk,
  input  wire rst_n,
  input  wire go_stop,
  input  wire go_wait,
  input  wire cpu_clk_run_q,
  output reg  stop_exec,
  output reg  wait_exec
);
  // A gated core retires nothing, so requests made while its clock is off are lost.
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stop_exec <= 1'b0;
      wait_exec <= 1'b0;
    end else begin
      stop_exec <= go_stop && cpu_clk_run_q;
      wait_exec <= go_wait && cpu_clk_run_q && !go_stop;
    end
  end
endmodule

// ===== tb/power_mode_and_vector_control_test.sv
// Self-checking bench of the power mode and vector controller.
`timescale 1ns/1ps
`include "power_vec_regs.vh"
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin miscompares++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module power_mode_and_vector_control_test;
  reg         core_clk, rst_n, reg_wr, reg_rd, go_stop, go_wait, nvm_busy, nmi_n, mi_n, per_w, dbg, xm, im;
  reg  [7:0]  reg_addr, base, gate;
  reg  [15:0] reg_wdata, int_req;
  reg  [3:0]  rst_evt;
  reg  [3:0]  idx, j;
  wire [15:0] reg_rdata_q, int_vector_q, reset_vector_q;
  wire [7:0]  periph_clk_gate_q;
  wire [2:0]  mode_q;
  wire        sys_clk_run_q, cpu_clk_run_q, osc_run_q, pll_self_clk_q, periph_on_q, stop_exec, wait_exec;
  wire        freeze_timer_q, freeze_pwm_q, freeze_analog_q, int_valid_q, sys_reset_req_q;
  wire        tick_run_q, watchdog_run_q, display_run_q, periodic_run_q, analog_run_q;
  wire [8:0]  units;
  int         miscompares, cmp_count, seed, i;
  assign units = {sys_clk_run_q, cpu_clk_run_q, osc_run_q, periph_on_q,
                  tick_run_q, watchdog_run_q, display_run_q, periodic_run_q, analog_run_q};
  power_mode_ctrl power_mode_ctrl_inst (.core_clk(core_clk), .rst_n(rst_n), .clk_en(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .stop_exec(stop_exec),
    .wait_exec(wait_exec), .nvm_busy(nvm_busy), .cpu_x_mask(xm), .cpu_i_mask(im),
    .nonmaskable_request_pin_n(nmi_n), .maskable_request_pin_n(mi_n), .int_req(int_req),
    .periodic_wake_req(per_w), .analog_wake_req(1'b0), .background_debug_active(dbg),
    .low_voltage_evt(rst_evt[2]), .illegal_addr_evt(rst_evt[3]), .clock_monitor_fail(rst_evt[0]),
    .watchdog_timeout(rst_evt[1]), .mode_q(mode_q), .sys_clk_run_q(sys_clk_run_q), .cpu_clk_run_q(cpu_clk_run_q),
    .osc_run_q(osc_run_q), .pll_self_clk_q(pll_self_clk_q), .tick_run_q(tick_run_q),
    .watchdog_run_q(watchdog_run_q), .display_run_q(display_run_q), .periodic_run_q(periodic_run_q),
    .analog_run_q(analog_run_q), .periph_on_q(periph_on_q), .periph_clk_gate_q(periph_clk_gate_q),
    .freeze_timer_q(freeze_timer_q), .freeze_pwm_q(freeze_pwm_q), .freeze_analog_q(freeze_analog_q),
    .int_valid_q(int_valid_q), .int_vector_q(int_vector_q), .sys_reset_req_q(sys_reset_req_q),
    .reset_vector_q(reset_vector_q));
  cpu_core_model cpu_core_model_inst (.core_clk(core_clk), .rst_n(rst_n), .go_stop(go_stop), .go_wait(go_wait),
    .cpu_clk_run_q(cpu_clk_run_q), .stop_exec(stop_exec), .wait_exec(wait_exec));
  function [15:0] vec_of(input [7:0] b, input [3:0] k);
    vec_of = {b, 8'hF8 - {3'h0, k, 1'b0}};
  endfunction
  task end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task wr(input [7:0] a, input [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input [7:0] a, input [15:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK("rdata", e, reg_rdata_q)
  endtask
  task cpu(input s);
    @(posedge core_clk);
    if (s) go_stop <= 1'b1;
    else go_wait <= 1'b1;
    @(posedge core_clk);
    go_stop <= 1'b0;
    go_wait <= 1'b0;
  endtask
  task wait_mode(input [2:0] m);
    int k;
    for (k = 0; k < 30 && mode_q !== m; k++) begin
      @(posedge core_clk);
      #1;
    end
    `CHK("mode", m, mode_q)
  endtask
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // The tests need well under a thousand cycles; this cuts a hang at 12500 cycles, far beyond that.
  initial begin
    #100000;
    miscompares++;
    end_sim;
  end
  initial begin
    {rst_n, reg_wr, reg_rd, go_stop, go_wait, nvm_busy, per_w, dbg, xm, im} = 10'h000;
    {nmi_n, mi_n} = 2'b11;
    {reg_addr, reg_wdata, int_req, rst_evt} = 44'h0;
    {miscompares, cmp_count, seed} = {32'd0, 32'd0, 32'd80};
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(`ADDR_CLOCK_SELECT, 16'h0000);
    rd(`ADDR_VECTOR_BASE, 16'h00FF);
    rd(`ADDR_INT_ENABLE, 16'h0003);
    rd(`ADDR_RESET_CTRL, 16'h0001);
    rd(8'h3C, 16'h0000);
    base = $random(seed);
    wr(`ADDR_VECTOR_BASE, {8'h00, base});
    rd(`ADDR_VECTOR_BASE, {8'h00, base});
    wr(`ADDR_INT_ENABLE, 16'hFFFF);
    wr(`ADDR_CLOCK_SELECT, 16'h000C);
    $display("test registers done");
    @(posedge core_clk) nvm_busy <= 1'b1;
    cpu(1'b1);
    wait_mode(3'd1);
    @(posedge core_clk) nvm_busy <= 1'b0;
    wait_mode(3'd3);
    `CHK("full stop outputs", 9'h003, units)
    @(posedge core_clk) int_req <= 16'h0020;
    repeat (6) @(posedge core_clk);
    #1;
    `CHK("timer no stop wake", 3'd3, mode_q)
    @(posedge core_clk) per_w <= 1'b1;
    wait_mode(3'd0);
    `CHK("vector", vec_of(base, 4'd5), int_vector_q)
    @(posedge core_clk) {per_w, int_req} <= 17'h0;
    wr(`ADDR_CLOCK_SELECT, 16'h0051);
    cpu(1'b1);
    wait_mode(3'd2);
    `CHK("osc", 1'b1, osc_run_q)
    `CHK("pseudo stop outputs", 9'h054, units)
    @(posedge core_clk) nmi_n <= 1'b0;
    wait_mode(3'd0);
    `CHK("vector", vec_of(base, 4'd2), int_vector_q)
    @(posedge core_clk) nmi_n <= 1'b1;
    repeat (4) @(posedge core_clk) nvm_busy <= 1'b1;
    cpu(1'b1);
    wait_mode(3'd1);
    @(posedge core_clk) int_req <= 16'h0010;
    wait_mode(3'd0);
    `CHK("vector", vec_of(base, 4'd4), int_vector_q)
    @(posedge core_clk) {nvm_busy, int_req} <= 17'h0;
    $display("test stop modes done");
    for (i = 0; i < 6; i++) begin
      idx = 4'd5 + $unsigned($random(seed)) % 11;
      j = (i == 0) ? 4'd15 : 4'd5 + $unsigned($random(seed)) % 11;
      gate = $random(seed);
      wr(`ADDR_CLOCK_GATE, {8'h00, gate});
      cpu(1'b0);
      wait_mode(3'd4);
      `CHK("gate", gate, periph_clk_gate_q)
      `CHK("wait outputs", 9'h17C, units)
      @(posedge core_clk) int_req <= (16'h1 << idx) | (16'h1 << j);
      wait_mode(3'd0);
      `CHK("vector", vec_of(base, (idx < j) ? idx : j), int_vector_q)
      `CHK("valid", 1'b1, int_valid_q)
      @(posedge core_clk) int_req <= 16'h0;
    end
    $display("test wait done");
    wr(`ADDR_CLOCK_SELECT, 16'h0006);
    cpu(1'b1);
    wait_mode(3'd3);
    @(posedge core_clk) mi_n <= 1'b0;
    wait_mode(3'd0);
    `CHK("fast wake", 2'b01, {osc_run_q, pll_self_clk_q})
    `CHK("vector", vec_of(base, 4'd3), int_vector_q)
    rd(`ADDR_STATUS, 16'h0038);
    rd(`ADDR_VECTOR, vec_of(base, 4'd3));
    @(posedge core_clk) mi_n <= 1'b1;
    @(posedge core_clk) {im, int_req} <= {1'b1, 16'h0012};
    repeat (2) @(posedge core_clk);
    #1;
    `CHK("unmaskable", {1'b1, vec_of(base, 4'd1)}, {int_valid_q, int_vector_q})
    @(posedge core_clk) {xm, nmi_n, int_req} <= {1'b1, 1'b0, 16'h0010};
    repeat (3) @(posedge core_clk);
    #1;
    `CHK("all masked", 1'b0, int_valid_q)
    @(posedge core_clk) im <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    `CHK("x masked", vec_of(base, 4'd4), int_vector_q)
    @(posedge core_clk) {xm, nmi_n, int_req} <= {1'b0, 1'b1, 16'h0000};
    wr(`ADDR_FREEZE_CTRL, 16'h0003);
    @(posedge core_clk) dbg <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    `CHK("freeze", 3'b110, {freeze_timer_q, freeze_pwm_q, freeze_analog_q})
    $display("test wake and freeze done");
    wr(`ADDR_RESET_CTRL, 16'h0005);
    for (i = 0; i < 4; i++) begin
      @(posedge core_clk) rst_evt <= 4'b0001 << i;
      @(posedge core_clk) rst_evt <= 4'b0000;
      #1;
      `CHK("reset req", 1'b1, sys_reset_req_q)
      `CHK("reset vector", (i == 0) ? 16'hFFFC : (i == 1) ? 16'hFFFA : 16'hFFFE, reset_vector_q)
    end
    $display("test resets done");
    end_sim;
  end
endmodule

// ===== tb/power_mode_ctrl_asserts.sv
// Concurrent checks on the ports of the power mode controller.
`timescale 1ns/1ps
module power_mode_ctrl_asserts (
  input wire        core_clk,
  input wire        rst_n,
  input wire        clk_en,
  input wire        stop_exec,
  input wire        nvm_busy,
  input wire        low_voltage_evt,
  input wire        clock_monitor_fail,
  input wire        watchdog_timeout,
  input wire        nonmaskable_request_pin_n,
  input wire        cpu_x_mask,
  input wire        background_debug_active,
  input wire [2:0]  mode_q,
  input wire        sys_clk_run_q,
  input wire        cpu_clk_run_q,
  input wire        osc_run_q,
  input wire        periph_on_q,
  input wire        freeze_timer_q,
  input wire        int_valid_q,
  input wire [15:0] int_vector_q,
  input wire        sys_reset_req_q,
  input wire [15:0] reset_vector_q
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_stop_go;
    clk_en && stop_exec && mode_q == 3'd0 && !low_voltage_evt && !clock_monitor_fail && !watchdog_timeout;
  endsequence
  sequence s_xreq;
    clk_en && !nonmaskable_request_pin_n && !cpu_x_mask;
  endsequence
  property p_stop_enter;
    s_stop_go ##0 !nvm_busy |=> mode_q == 3'd2 || mode_q == 3'd3;
  endproperty
  a_stop_enter: assert property (p_stop_enter) else $error("stop entry missed");
  property p_defer;
    s_stop_go ##0 nvm_busy |=> mode_q == 3'd1 && sys_clk_run_q;
  endproperty
  a_defer: assert property (p_defer) else $error("deferred stop wrong");
  property p_full;
    mode_q == 3'd3 |-> !sys_clk_run_q && !cpu_clk_run_q && !osc_run_q;
  endproperty
  a_full: assert property (p_full) else $error("full stop clocks wrong");
  property p_pseudo;
    mode_q == 3'd2 |-> !sys_clk_run_q && osc_run_q && !periph_on_q;
  endproperty
  a_pseudo: assert property (p_pseudo) else $error("pseudo stop clocks wrong");
  property p_wait;
    mode_q == 3'd4 |-> !cpu_clk_run_q && sys_clk_run_q;
  endproperty
  a_wait: assert property (p_wait) else $error("wait clocks wrong");
  property p_xwake;
    (mode_q == 3'd2 || mode_q == 3'd3 || mode_q == 3'd4) ##0 s_xreq [*3] |-> ##[1:2] mode_q == 3'd0;
  endproperty
  a_xwake: assert property (p_xwake) else $error("pin did not wake");
  property p_valid;
    int_valid_q |-> mode_q == 3'd0 && !int_vector_q[0] && int_vector_q[7:0] >= 8'hDA && int_vector_q[7:0] <= 8'hF8;
  endproperty
  a_valid: assert property (p_valid) else $error("vector offset wrong");
  property p_lvr;
    clk_en && low_voltage_evt && !clock_monitor_fail && !watchdog_timeout |=> sys_reset_req_q && reset_vector_q == 16'hFFFE;
  endproperty
  a_lvr: assert property (p_lvr) else $error("reset vector wrong");
  property p_freeze;
    clk_en && !background_debug_active |=> !freeze_timer_q;
  endproperty
  a_freeze: assert property (p_freeze) else $error("freeze without debug");
endmodule
bind power_mode_ctrl power_mode_ctrl_asserts power_mode_ctrl_asserts_inst (
  .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .stop_exec(stop_exec), .nvm_busy(nvm_busy),
  .low_voltage_evt(low_voltage_evt), .clock_monitor_fail(clock_monitor_fail), .watchdog_timeout(watchdog_timeout),
  .nonmaskable_request_pin_n(nonmaskable_request_pin_n), .cpu_x_mask(cpu_x_mask),
  .background_debug_active(background_debug_active), .mode_q(mode_q), .sys_clk_run_q(sys_clk_run_q),
  .cpu_clk_run_q(cpu_clk_run_q), .osc_run_q(osc_run_q), .periph_on_q(periph_on_q),
  .freeze_timer_q(freeze_timer_q), .int_valid_q(int_valid_q), .int_vector_q(int_vector_q),
  .sys_reset_req_q(sys_reset_req_q), .reset_vector_q(reset_vector_q)
);
